// ==== rtl/rccr_map.svh ====
// register offsets, fields, reset values and timing figures of the repeater channel bank
// How it works
// - auto bit picks detector, else manual mute
// - manual mute bit mutes output when set
// - sense mode 00 keeps input high impedance
// - mode 01 probes every 12 ms, 50 times
// - mode 10 probes every 12 ms until found
// - mode 11 termination permanent; register beats strap
// - swing bit 7 gates short-circuit protection
// - swing bit 6 forces gen 1/2 or 3
// - swing code 000..111 gives 0.7..1.4 V
// - status bit 7 reports far receiver found
// - status bits 6:5 report detected link speed
// - three-bit de-emphasis code selects 0..-12 dB
// - idle release threshold code, overrides strap
// - idle entry threshold code bits 1:0
`ifndef RCCR_MAP_SVH
`define RCCR_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define RCCR_OFS_IDLE_CTRL 8'h40
`define RCCR_OFS_EQUALIZER 8'h41
`define RCCR_OFS_SWING 8'h42
`define RCCR_OFS_STATUS_DEEMPH 8'h43
`define RCCR_OFS_IDLE_THRESH 8'h44
`define RCCR_OFS_PART_ID 8'h51

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RCCR_RST_IDLE_CTRL 8'h00
`define RCCR_RST_EQUALIZER 8'h2f
`define RCCR_RST_SWING 8'had
`define RCCR_RST_DEEMPH 5'h02
`define RCCR_RST_IDLE_THRESH 8'h00

////////////////////////////////////////////////////////////////////////////////
// field positions
`define RCCR_IDLE_AUTO_BIT 5
`define RCCR_IDLE_SEL_BIT 4
`define RCCR_SENSE_MSB 3
`define RCCR_SENSE_LSB 2
`define RCCR_SCP_BIT 7
`define RCCR_RATE_SEL_BIT 6
`define RCCR_STAT_FOUND_BIT 7

////////////////////////////////////////////////////////////////////////////////
// sense modes
`define RCCR_SENSE_OFF 2'h0
`define RCCR_SENSE_RUN50 2'h1
`define RCCR_SENSE_FREE 2'h2
`define RCCR_SENSE_FIXED 2'h3

////////////////////////////////////////////////////////////////////////////////
// timing
`define RCCR_CLK_PERIOD_NS 10
`define RCCR_PROBE_INTERVAL_NS 12000000
`define RCCR_PROBE_WINDOW_NS 600000000

`endif

// ==== rtl/rccr_pkg.sv ====
// types shared by the repeater channel register bank
`default_nettype none
package rccr_pkg;
  // receiver sense sequencer, gray along off-wait-probe-done
  typedef enum logic [1:0] {
    DET_OFF = 2'h0,
    DET_WAIT = 2'h1,
    DET_PROBE = 2'h3,
    DET_DONE = 2'h2
  } rccr_det_state_t;
endpackage
`default_nettype wire

// ==== rtl/rccr_channel_regs.sv ====
// per-channel configuration and status registers with receiver sense sequencing
`timescale 1ns/1ps
`default_nettype none
`include "rccr_map.svh"

module rccr_channel_regs #(
  parameter int unsigned PROBE_INTERVAL_CYC = `RCCR_PROBE_INTERVAL_NS / `RCCR_CLK_PERIOD_NS,
  parameter int unsigned PROBE_ATTEMPTS = `RCCR_PROBE_WINDOW_NS / `RCCR_PROBE_INTERVAL_NS,
  parameter logic [7:0] PART_CODE = 8'h5a // arbitrary identity value
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic reg_wr_en, // register write strobe
  input wire logic reg_rd_en, // register read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, one cycle after strobe
  input wire logic idle_det_in, // idle detector says input is idle
  input wire logic rx_present_in, // probe result, valid while rx_probe high
  input wire logic [1:0] detected_speed_status_in, // live speed detector result
  output logic out_mute, // output held in electrical idle
  output logic term_50ohm, // input termination 50 ohm, else high-z
  output logic rx_probe, // one-cycle receiver probe request
  output logic scp_enable, // short-circuit protection on
  output logic rate_force_gen12, // force gen 1/2, else gen 3
  output logic [2:0] output_swing_level, // swing code
  output logic [2:0] deemphasis_level, // de-emphasis code
  output logic [7:0] receive_equalizer_level, // equalizer setting
  output logic [1:0] idle_release_thresh, // idle release threshold code
  output logic [1:0] idle_entry_thresh // idle entry threshold code
);

  localparam int CW = (PROBE_INTERVAL_CYC > 1) ? $clog2(PROBE_INTERVAL_CYC) : 1;
  localparam int AW = $clog2(PROBE_ATTEMPTS + 1);
  localparam logic [CW-1:0] TICK_LOAD = CW'(PROBE_INTERVAL_CYC - 1);
  localparam logic [AW-1:0] LAST_TRY = AW'(PROBE_ATTEMPTS - 1);

  // the counters cannot serve an empty interval or attempt budget
  if (PROBE_INTERVAL_CYC < 1 || PROBE_ATTEMPTS < 1) begin : g_bad_params
    $error("probe interval and attempt count must be at least one");
  end

  typedef struct packed {
    logic [7:0] idle_ctrl;
    logic [7:0] equalizer;
    logic [7:0] swing;
    logic [4:0] deemph;
    logic [7:0] thresh;
    logic rx_found;
    logic [1:0] speed;
    logic mute;
    logic term;
    logic probe;
    rccr_pkg::rccr_det_state_t det;
    logic [CW-1:0] tick;
    logic [AW-1:0] tries;
    logic [1:0] mode_seen;
    logic [7:0] rdata;
  } rccr_state_t;

  rccr_state_t st_ff;
  rccr_state_t nxt_st;
  logic [1:0] sense_mode;
  logic sense_active;

  assign sense_mode = st_ff.idle_ctrl[`RCCR_SENSE_MSB:`RCCR_SENSE_LSB];
  assign sense_active = (sense_mode == `RCCR_SENSE_RUN50) || (sense_mode == `RCCR_SENSE_FREE);

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic: register writes, reads, idle control and sensing
  always_comb begin
    nxt_st = st_ff;
    nxt_st.probe = 1'b0;
    // speed status follows the speed detector every cycle, not only on read
    nxt_st.speed = detected_speed_status_in;

    // writes; reserved patterns are stored as given, the host keeps them
    if (reg_wr_en) begin
      if (reg_addr == `RCCR_OFS_IDLE_CTRL) begin
        nxt_st.idle_ctrl = reg_wdata;
      end else if (reg_addr == `RCCR_OFS_EQUALIZER) begin
        nxt_st.equalizer = reg_wdata;
      end else if (reg_addr == `RCCR_OFS_SWING) begin
        nxt_st.swing = reg_wdata;
      end else if (reg_addr == `RCCR_OFS_STATUS_DEEMPH) begin
        nxt_st.deemph = reg_wdata[4:0];
      end else if (reg_addr == `RCCR_OFS_IDLE_THRESH) begin
        nxt_st.thresh = reg_wdata;
      end
    end

    // reads; unmapped offsets answer zero
    if (reg_rd_en) begin
      if (reg_addr == `RCCR_OFS_IDLE_CTRL) begin
        nxt_st.rdata = st_ff.idle_ctrl;
      end else if (reg_addr == `RCCR_OFS_EQUALIZER) begin
        nxt_st.rdata = st_ff.equalizer;
      end else if (reg_addr == `RCCR_OFS_SWING) begin
        nxt_st.rdata = st_ff.swing;
      end else if (reg_addr == `RCCR_OFS_STATUS_DEEMPH) begin
        nxt_st.rdata = {st_ff.rx_found, st_ff.speed, st_ff.deemph};
      end else if (reg_addr == `RCCR_OFS_IDLE_THRESH) begin
        nxt_st.rdata = st_ff.thresh;
      end else if (reg_addr == `RCCR_OFS_PART_ID) begin
        nxt_st.rdata = PART_CODE;
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end

    // idle: detector in auto, else the manual mute bit
    if (st_ff.idle_ctrl[`RCCR_IDLE_AUTO_BIT]) begin
      nxt_st.mute = idle_det_in;
    end else begin
      nxt_st.mute = st_ff.idle_ctrl[`RCCR_IDLE_SEL_BIT];
    end

    // receiver sensing; a mode change restarts the sequence from scratch
    nxt_st.mode_seen = sense_mode;
    if (sense_mode != st_ff.mode_seen) begin
      nxt_st.det = rccr_pkg::DET_OFF;
      nxt_st.rx_found = 1'b0;
    end else begin
      case (st_ff.det)
        rccr_pkg::DET_OFF: begin
          nxt_st.tick = TICK_LOAD;
          nxt_st.tries = '0;
          if (sense_active) begin
            nxt_st.det = rccr_pkg::DET_WAIT;
          end
        end
        rccr_pkg::DET_WAIT: begin
          if (st_ff.tick == '0) begin
            nxt_st.det = rccr_pkg::DET_PROBE;
            nxt_st.probe = 1'b1;
          end else begin
            nxt_st.tick = st_ff.tick - 1'b1;
          end
        end
        rccr_pkg::DET_PROBE: begin
          if (rx_present_in) begin
            nxt_st.rx_found = 1'b1;
            nxt_st.det = rccr_pkg::DET_DONE;
          end else if (sense_mode == `RCCR_SENSE_RUN50 && st_ff.tries == LAST_TRY) begin
            // budget spent: give up, input stays high impedance
            nxt_st.tries = st_ff.tries + 1'b1;
            nxt_st.det = rccr_pkg::DET_DONE;
          end else begin
            // free-running mode holds the count; only mode 01 is capped
            nxt_st.tries = (sense_mode == `RCCR_SENSE_RUN50) ? st_ff.tries + 1'b1 : st_ff.tries;
            nxt_st.tick = TICK_LOAD;
            nxt_st.det = rccr_pkg::DET_WAIT;
          end
        end
        rccr_pkg::DET_DONE: begin
          nxt_st.det = rccr_pkg::DET_DONE;
        end
        default: begin
          nxt_st.det = rccr_pkg::DET_OFF;
        end
      endcase
    end

    // termination: register mode decides, no strap is consulted
    if (sense_mode == `RCCR_SENSE_FIXED) begin
      nxt_st.term = 1'b1;
    end else if (sense_mode == `RCCR_SENSE_OFF) begin
      nxt_st.term = 1'b0;
    end else begin
      nxt_st.term = st_ff.rx_found;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.idle_ctrl <= `RCCR_RST_IDLE_CTRL;
      st_ff.equalizer <= `RCCR_RST_EQUALIZER;
      st_ff.swing <= `RCCR_RST_SWING;
      st_ff.deemph <= `RCCR_RST_DEEMPH;
      st_ff.thresh <= `RCCR_RST_IDLE_THRESH;
      st_ff.det <= rccr_pkg::DET_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from the state register
  assign reg_rdata = st_ff.rdata;
  assign out_mute = st_ff.mute;
  assign term_50ohm = st_ff.term;
  assign rx_probe = st_ff.probe;
  assign scp_enable = st_ff.swing[`RCCR_SCP_BIT];
  assign rate_force_gen12 = st_ff.swing[`RCCR_RATE_SEL_BIT];
  assign output_swing_level = st_ff.swing[2:0];
  assign deemphasis_level = st_ff.deemph[2:0];
  assign receive_equalizer_level = st_ff.equalizer;
  assign idle_release_thresh = st_ff.thresh[3:2];
  assign idle_entry_thresh = st_ff.thresh[1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_auto_idle_follow: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.idle_ctrl[`RCCR_IDLE_AUTO_BIT] |=> out_mute == $past(idle_det_in))
    else $error("auto idle mute does not follow detector");

  a_manual_mute: assert property (@(posedge sys_clk) disable iff (rst)
    !st_ff.idle_ctrl[`RCCR_IDLE_AUTO_BIT] |=> out_mute == $past(st_ff.idle_ctrl[`RCCR_IDLE_SEL_BIT]))
    else $error("manual mute not applied");

  a_off_high_z: assert property (@(posedge sys_clk) disable iff (rst)
    (sense_mode == `RCCR_SENSE_OFF) [*2] |=> !term_50ohm && !rx_probe)
    else $error("mode 00 terminated or probed");

  a_try_budget: assert property (@(posedge sys_clk) disable iff (rst)
    (sense_mode == `RCCR_SENSE_RUN50 && st_ff.det == rccr_pkg::DET_DONE && !st_ff.rx_found)
      |-> st_ff.tries == AW'(PROBE_ATTEMPTS))
    else $error("mode 01 stopped at wrong attempt count");

  a_probe_spacing: assert property (@(posedge sys_clk) disable iff (rst)
    rx_probe && !rx_present_in && sense_mode == `RCCR_SENSE_FREE && sense_mode == st_ff.mode_seen
      |=> (!rx_probe && st_ff.tick == TICK_LOAD))
    else $error("probe interval not restarted");

  a_found_term: assert property (@(posedge sys_clk) disable iff (rst)
    rx_probe && rx_present_in && sense_active && sense_mode == st_ff.mode_seen
      ##1 sense_mode == $past(sense_mode) |=> term_50ohm)
    else $error("termination not applied after detection");

  a_fixed_term: assert property (@(posedge sys_clk) disable iff (rst)
    sense_mode == `RCCR_SENSE_FIXED |=> term_50ohm)
    else $error("mode 11 not terminated");

  a_scp_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_addr == `RCCR_OFS_SWING |=> scp_enable == $past(reg_wdata[7]))
    else $error("protection bit not taken");

  a_rate_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_addr == `RCCR_OFS_SWING |=> rate_force_gen12 == $past(reg_wdata[6]))
    else $error("rate force bit not taken");

  a_speed_live: assert property (@(posedge sys_clk) disable iff (rst)
    ##2 reg_rd_en && reg_addr == `RCCR_OFS_STATUS_DEEMPH |=> reg_rdata[6:5] == $past(detected_speed_status_in, 2))
    else $error("speed status stale");

  a_found_read: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd_en && reg_addr == `RCCR_OFS_STATUS_DEEMPH |=> reg_rdata[7] == $past(st_ff.rx_found))
    else $error("found status wrong");

  // receiver sense sequencing, step by step
  a_probe_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    rx_probe |=> !rx_probe)
    else $error("probe request longer than one cycle");

  a_probe_mode: assert property (@(posedge sys_clk) disable iff (rst)
    rx_probe |-> (st_ff.mode_seen == `RCCR_SENSE_RUN50 || st_ff.mode_seen == `RCCR_SENSE_FREE))
    else $error("probe outside an automatic sense mode");

  a_done_no_probe: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.det == rccr_pkg::DET_DONE |=> !rx_probe)
    else $error("probe after the sequence ended");

  a_fixed_no_probe: assert property (@(posedge sys_clk) disable iff (rst)
    (sense_mode == `RCCR_SENSE_FIXED) [*2] |=> !rx_probe)
    else $error("mode 11 probed");

  a_fixed_not_found: assert property (@(posedge sys_clk) disable iff (rst)
    (sense_mode == `RCCR_SENSE_FIXED) [*2] |=> !st_ff.rx_found)
    else $error("mode 11 reports a receiver");

  a_off_not_found: assert property (@(posedge sys_clk) disable iff (rst)
    (sense_mode == `RCCR_SENSE_OFF) [*2] |=> !st_ff.rx_found)
    else $error("mode 00 reports a receiver");

  a_change_restart: assert property (@(posedge sys_clk) disable iff (rst)
    sense_mode != st_ff.mode_seen |=> st_ff.det == rccr_pkg::DET_OFF && !st_ff.rx_found)
    else $error("mode change did not restart sensing");

  a_off_starts_wait: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.det == rccr_pkg::DET_OFF && sense_active && sense_mode == st_ff.mode_seen
      |=> st_ff.det == rccr_pkg::DET_WAIT && st_ff.tick == TICK_LOAD)
    else $error("sensing did not start its interval");

  a_wait_countdown: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.det == rccr_pkg::DET_WAIT && st_ff.tick != '0 && sense_mode == st_ff.mode_seen
      |=> st_ff.det == rccr_pkg::DET_WAIT && !rx_probe)
    else $error("probe before the interval ran out");

  a_probe_on_zero: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.det == rccr_pkg::DET_WAIT && st_ff.tick == '0 && sense_mode == st_ff.mode_seen
      |=> rx_probe && st_ff.det == rccr_pkg::DET_PROBE)
    else $error("probe missing at end of interval");

  a_hit_sets_found: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.det == rccr_pkg::DET_PROBE && rx_present_in && sense_mode == st_ff.mode_seen
      |=> st_ff.rx_found && st_ff.det == rccr_pkg::DET_DONE)
    else $error("successful probe not recorded");

  a_found_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.rx_found && sense_mode == st_ff.mode_seen |=> st_ff.rx_found)
    else $error("found status lost without mode change");

  a_found_needs_probe: assert property (@(posedge sys_clk) disable iff (rst)
    !st_ff.rx_found && !(st_ff.det == rccr_pkg::DET_PROBE && rx_present_in) |=> !st_ff.rx_found)
    else $error("found status set without a probe");

  a_term_follows: assert property (@(posedge sys_clk) disable iff (rst)
    sense_active |=> term_50ohm == $past(st_ff.rx_found))
    else $error("termination does not follow detection");

  // configuration fields take writes and hold otherwise
  a_swing_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_addr == `RCCR_OFS_SWING |=> output_swing_level == $past(reg_wdata[2:0]))
    else $error("swing code not taken");

  a_deemph_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_addr == `RCCR_OFS_STATUS_DEEMPH |=> deemphasis_level == $past(reg_wdata[2:0]))
    else $error("de-emphasis code not taken");

  a_release_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_addr == `RCCR_OFS_IDLE_THRESH |=> idle_release_thresh == $past(reg_wdata[3:2]))
    else $error("release threshold not taken");

  a_entry_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_addr == `RCCR_OFS_IDLE_THRESH |=> idle_entry_thresh == $past(reg_wdata[1:0]))
    else $error("entry threshold not taken");

  a_swing_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr_en && reg_addr == `RCCR_OFS_SWING) |=> $stable({scp_enable, rate_force_gen12, output_swing_level}))
    else $error("swing register changed without write");

  a_deemph_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr_en && reg_addr == `RCCR_OFS_STATUS_DEEMPH) |=> $stable(deemphasis_level))
    else $error("de-emphasis changed without write");

  a_thresh_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr_en && reg_addr == `RCCR_OFS_IDLE_THRESH) |=> $stable({idle_release_thresh, idle_entry_thresh}))
    else $error("thresholds changed without write");

  // status and idle control
  a_status_ro: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_addr == `RCCR_OFS_STATUS_DEEMPH && st_ff.det != rccr_pkg::DET_PROBE
      && sense_mode == st_ff.mode_seen |=> st_ff.rx_found == $past(st_ff.rx_found))
    else $error("write reached the found status");

  a_speed_track: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> st_ff.speed == $past(detected_speed_status_in))
    else $error("speed status not refreshed");

  a_mute_when_set: assert property (@(posedge sys_clk) disable iff (rst)
    !st_ff.idle_ctrl[`RCCR_IDLE_AUTO_BIT] && st_ff.idle_ctrl[`RCCR_IDLE_SEL_BIT] |=> out_mute)
    else $error("manual mute bit set but output on");

  a_auto_not_idle: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.idle_ctrl[`RCCR_IDLE_AUTO_BIT] && !idle_det_in |=> !out_mute)
    else $error("auto idle muted an active input");

endmodule
`default_nettype wire

// ==== test/rccr_far_rx.sv ====
// far-side receiver model answering presence probes
`timescale 1ns/1ps
`default_nettype none
module rccr_far_rx (
  input wire logic sys_clk, // channel clock
  input wire logic rx_probe, // probe request
  input wire logic present, // receiver plugged in
  output logic rx_present_in // probe answer
);
  logic junk_ff = 1'b0;
  // answer valid only in the probe cycle; toggles otherwise so stale use shows
  always @(posedge sys_clk) begin
    junk_ff <= ~junk_ff;
  end
  assign rx_present_in = rx_probe ? present : junk_ff;
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the repeater channel register bank
`timescale 1ns/1ps
`default_nettype none
`include "rccr_map.svh"
module testbench;
  logic sys_clk, rst, wr_en, rd_en, idle_det, present, rx_pres;
  logic mute, term, probe, scp, gen12;
  logic [7:0] addr, wdata, rdata, eq;
  logic [2:0] swing, deemph;
  logic [1:0] rate, rel_th, ent_th;
  logic [7:0] ofs [7] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h51, 8'h50};
  logic [7:0] rv [7] = '{8'h00, 8'h2f, 8'had, 8'h02, 8'h00, 8'h3c, 8'h00};
  logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};
  int n_fail = 0;
  int n_checks = 0;
  int n_probe = 0;
  int cyc = 0;

  // short counts keep the probe sequencer inside a few hundred cycles
  rccr_channel_regs #(.PROBE_INTERVAL_CYC(8), .PROBE_ATTEMPTS(3), .PART_CODE(8'h3c)) DUT (
    .sys_clk(sys_clk), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .idle_det_in(idle_det), .rx_present_in(rx_pres), .detected_speed_status_in(rate),
    .out_mute(mute), .term_50ohm(term), .rx_probe(probe), .scp_enable(scp),
    .rate_force_gen12(gen12), .output_swing_level(swing), .deemphasis_level(deemph),
    .receive_equalizer_level(eq), .idle_release_thresh(rel_th), .idle_entry_thresh(ent_th));
  rccr_far_rx far (.sys_clk(sys_clk), .rx_probe(probe), .present(present), .rx_present_in(rx_pres));

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one-cycle strobes, launched 1 ns after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge sys_clk);
    #1 wr_en = 1'b0;
    // one idle cycle so a following call never re-raises the strobe in this step
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd_en = 1'b1;
    @(posedge sys_clk);
    #1 rd_en = 1'b0;
    tick(1);
    chk($sformatf("reg %h", a), rdata, exp);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // probe counter and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (probe === 1'b1) n_probe++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    {rst, wr_en, rd_en, addr, wdata, idle_det, rate, present} = {1'b1, 22'h0};
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    tick(1);
    // reset values, unmapped read, write to read-only identity
    for (int i = 0; i < 7; i++) rd(ofs[i], rv[i]);
    chk("cfg", {scp, gen12, swing, deemph}, 8'b1_0_101_010);
    wr(8'h51, 8'hff);
    wr(8'h50, 8'hff);
    rd(8'h51, 8'h3c);
    rd(8'h50, 8'h00);
    // every swing, de-emphasis, threshold code and both control bit values
    for (int i = 0; i < 8; i++) begin
      wr(8'h42, {i[0], ~i[0], 3'b101, i[2:0]});
      wr(8'h43, {5'h00, i[2:0]});
      wr(8'h44, {4'h0, ~i[1:0], i[1:0]});
      wr(8'h41, 8'(i * 37));
      tick(1);
      chk("cfg", {scp, gen12, swing, deemph}, {i[0], ~i[0], i[2:0], i[2:0]});
      chk("thresh", {4'h0, rel_th, ent_th}, {4'h0, ~i[1:0], i[1:0]});
      chk("eq", eq, 8'(i * 37));
    end
    // status bits ignore writes and follow the speed detector
    for (int i = 0; i < 3; i++) begin
      rate = codes[i];
      wr(8'h43, 8'he5);
      rd(8'h43, {1'b0, codes[i], 5'h05});
    end
    // manual mute, then detector-driven idle overriding bit 4
    wr(8'h40, 8'h10);
    tick(1);
    chk("mute", {7'h0, mute}, 8'h01);
    wr(8'h40, 8'h00);
    tick(1);
    chk("mute", {7'h0, mute}, 8'h00);
    wr(8'h40, 8'h30);
    tick(2);
    chk("mute", {7'h0, mute}, 8'h00);
    idle_det = 1'b1;
    tick(2);
    chk("mute", {7'h0, mute}, 8'h01);
    idle_det = 1'b0;
    chk("probes", 8'(n_probe), 8'h00);
    chk("term", {7'h0, term}, 8'h00);
    // fixed termination, not reported as found
    wr(8'h40, 8'h0c);
    tick(3);
    chk("term", {7'h0, term}, 8'h01);
    rd(8'h43, 8'h65);
    // bounded attempts with nobody attached
    wr(8'h40, 8'h04);
    n_probe = 0;
    tick(80);
    chk("probes", 8'(n_probe), 8'h03);
    chk("term", {7'h0, term}, 8'h00);
    // unbounded attempts, then a receiver appears
    wr(8'h40, 8'h08);
    n_probe = 0;
    tick(50);
    chk("many probes", {7'h0, n_probe >= 4}, 8'h01);
    present = 1'b1;
    tick(14);
    chk("term", {7'h0, term}, 8'h01);
    rd(8'h43, 8'he5);
    wr(8'h40, 8'h00);
    tick(2);
    chk("term", {7'h0, term}, 8'h00);
    wr(8'h40, 8'h04);
    tick(16);
    chk("term", {7'h0, term}, 8'h01);
    // reset in mid-run drops termination and restores the defaults
    n_probe = 0;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(20);
    chk("term", {7'h0, term}, 8'h00);
    chk("probes", 8'(n_probe), 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h42, 8'had);
    results();
  end
endmodule
`default_nettype wire
